/* File: pvod_pkg.sv */
// Package of constants for the two-channel voltage-offset link decoder
// Functional notes
// RQ1 - Decode a channel only while its own pulse scaling enable bit is set.
// RQ2 - Only buck regulators 0 and 1 have pulse link scaling; 2 and 3 none.
// RQ3 - Channel 1 uses io3 clock, io2 data; channel 0 io4 clock, io5 data.
// RQ4 - Frame gives up to 32 steps of 12.5mV added to the base voltage.
// RQ5 - Base voltage comes from the ordinary output voltage setting register.
// RQ6 - Host clocks the link at 3 to 33 MHz; decoder works across that range.
// RQ7 - Data line sampled once per link clock over 32 consecutive periods.
// RQ8 - A rising edge of the data line starts a new frame; no other sync.
// RQ9 - No fixed frequency or duty needed; host keeps minimum low/high times.
// RQ10 - Regulator switched off while scaling clears its enable bit.
// RQ11 - Writing 1 to phase split bit of config word 0 splits regulator 0.
// RQ12 - Split mode: power good 0 pin becomes feedback a; ext enable becomes pg 1.
// RQ13 - Split mode: only half a accepts scaling; half b is register only.
// RQ14 - Step count is high samples in the frame, applied when the frame ends.
package pvod_pkg;
  // ----------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] BASE_VOLTAGE_SETTING_0_OFS = 8'h00;
  localparam logic [7:0] BASE_VOLTAGE_SETTING_1_OFS = 8'h04;
  localparam logic [7:0] SCALING_CTRL_OFS = 8'h08;
  localparam logic [7:0] CONFIGURATION_WORD_0_OFS = 8'h0c;
  localparam logic [7:0] OFFSET_STATUS_OFS = 8'h10;
  localparam logic [7:0] TARGET_0_OFS = 8'h14;
  localparam logic [7:0] TARGET_1_OFS = 8'h18;
  // ----------------------------------------
  // Fields and reset values
  // ----------------------------------------
  localparam int ENABLE_0_BIT = 0;
  localparam int ENABLE_1_BIT = 1;
  localparam int REG_ON_0_BIT = 4;
  localparam int REG_ON_1_BIT = 5;
  localparam int PHASE_SPLIT_BIT = 0;
  localparam int VOLT_W = 16;
  localparam int STEP_W = 6;
  localparam logic [VOLT_W-1:0] BASE_VOLTAGE_RST = 16'h0000;
  localparam logic [31:0] SCALING_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] CONFIG_RST = 32'h0000_0000;
  // ----------------------------------------
  // Timing and link constants
  // ----------------------------------------
  localparam int FRAME_SAMPLES = 32;
  localparam logic [STEP_W-1:0] MAX_STEPS = 6'h20;
  // Step of 12.5 mV expressed in units of 0.1 mV for the target register
  localparam logic [VOLT_W-1:0] STEP_UV100 = 16'h007d;
  localparam int LINK_FMIN_MHZ = 3;
  localparam int LINK_FMAX_MHZ = 33;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* File: pvod_decoder.sv */
// Two-channel voltage-offset link decoder with AXI4-Lite register file
`timescale 1ns/100ps
module pvod_decoder (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic link_clk_0,
  input wire logic link_clk_1,
  input wire logic link_srst,
  input wire logic general_io_2,
  input wire logic general_io_5,
  input wire logic power_good_state_0,
  input wire logic power_good_state_1,
  input wire logic external_regulator_enable_req,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [15:0] target_voltage_0,
  output logic [15:0] target_voltage_1,
  output logic [15:0] target_voltage_split_b,
  output logic phase_split_active,
  output logic pin_a38_is_feedback,
  output logic pin_a1_out,
  output logic power_good_out_0
);
  // ----------------------------------------
  // Link side, one decoder per channel
  // ----------------------------------------
  // Channel 0 clock on io4 / data io5, channel 1 clock on io3 / data io2
  logic [1:0] lk_clk;
  logic [1:0] lk_data;
  logic [1:0] lk_tog_q;
  logic [pvod_pkg::STEP_W-1:0] lk_count_q [2];
  logic [1:0] ack_sync_q1;
  logic [1:0] ack_sync_q2;
  logic [1:0] ack_prev_q;
  logic [1:0] frame_event;
  logic [pvod_pkg::STEP_W-1:0] steps_q [2];
  logic [1:0] enable_q;
  logic [1:0] reg_on_q;
  logic [1:0] reg_on_prev_q;
  logic [pvod_pkg::VOLT_W-1:0] base_q [2];
  logic split_q;

  assign lk_clk = {link_clk_1, link_clk_0}; // RQ3
  assign lk_data = {general_io_2, general_io_5}; // RQ3

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_link
      logic dat_prev_q;
      logic active_q;
      logic [5:0] cnt_q;
      logic [pvod_pkg::STEP_W-1:0] ones_q;
      logic [pvod_pkg::STEP_W-1:0] hold_q;
      logic tog_q;
      logic en_s1_q;
      logic en_s2_q;
      wire [pvod_pkg::STEP_W-1:0] bit_in = {{(pvod_pkg::STEP_W - 1){1'b0}}, lk_data[ch]};
      wire start = lk_data[ch] && !dat_prev_q && !active_q; // RQ8
      wire last = active_q && (cnt_q == 6'(pvod_pkg::FRAME_SAMPLES - 1));
      // Data is sampled on each rising link edge, so duty cycle never matters
      always_ff @(posedge lk_clk[ch]) begin // RQ6 RQ9
        // Enable crosses as a single bit, so two flops are enough
        en_s1_q <= enable_q[ch];
        en_s2_q <= en_s1_q;
        if (link_srst) begin
          dat_prev_q <= 1'b0;
          active_q <= 1'b0;
          cnt_q <= 6'h00;
          ones_q <= 6'h00;
          hold_q <= 6'h00;
          tog_q <= 1'b0;
        end else begin
          dat_prev_q <= lk_data[ch];
          if (start && en_s2_q) begin // RQ1
            active_q <= 1'b1;
            cnt_q <= 6'h01;
            ones_q <= 6'h01;
          end else if (active_q) begin
            cnt_q <= cnt_q + 6'h01; // RQ7
            if (last) begin
              active_q <= 1'b0;
              hold_q <= ones_q + bit_in; // RQ14
              tog_q <= ~tog_q;
            end else begin
              ones_q <= ones_q + bit_in;
            end
          end
        end
      end
      // ----------------------------------------
      // Link-side checks
      // ----------------------------------------
      sequence s_frame_open;
        start && en_s2_q;
      endsequence
      sequence s_frame_close;
        last;
      endsequence
      property p_open_count;
        @(posedge lk_clk[ch]) disable iff (link_srst)
          s_frame_open |=> active_q && cnt_q == 6'h01;
      endproperty
      a_open_count: assert property (p_open_count) else $error("frame did not open on data rise"); // RQ8
      property p_close_idle;
        @(posedge lk_clk[ch]) disable iff (link_srst)
          s_frame_close |=> !active_q && tog_q != $past(tog_q);
      endproperty
      a_close_idle: assert property (p_close_idle) else $error("frame did not close after last sample"); // RQ7
      property p_count_range;
        @(posedge lk_clk[ch]) disable iff (link_srst)
          active_q |-> cnt_q != 6'h00 && cnt_q <= 6'(pvod_pkg::FRAME_SAMPLES - 1);
      endproperty
      a_count_range: assert property (p_count_range) else $error("sample count out of frame"); // RQ7
      property p_idle_when_off;
        @(posedge lk_clk[ch]) disable iff (link_srst)
          !active_q && !en_s2_q |=> !active_q;
      endproperty
      a_idle_when_off: assert property (p_idle_when_off) else $error("frame opened while disabled"); // RQ1
      property p_hold_max;
        @(posedge lk_clk[ch]) disable iff (link_srst) hold_q <= pvod_pkg::MAX_STEPS;
      endproperty
      a_hold_max: assert property (p_hold_max) else $error("frame count above 32"); // RQ14
      assign lk_tog_q[ch] = tog_q;
      assign lk_count_q[ch] = hold_q;
    end
  endgenerate

  // ----------------------------------------
  // Crossing of the frame toggle
  // ----------------------------------------
  // Count is stable long before the toggle lands, so it is sampled on the event
  always_ff @(posedge ref_clk) begin
    ack_sync_q1 <= lk_tog_q;
    ack_sync_q2 <= ack_sync_q1;
    ack_prev_q <= srst ? 2'b00 : ack_sync_q2;
  end
  assign frame_event = ack_sync_q2 ^ ack_prev_q;

  // ----------------------------------------
  // Register bus
  // ----------------------------------------
  logic aw_held_q;
  logic w_held_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic [31:0] ctrl_word;
  logic [31:0] status_word;
  logic [31:0] rd_mux;
  logic rd_hit;
  logic wr_hit;
  wire wr_go = aw_held_q && w_held_q && !bvalid_q;
  wire wr_base0 = wr_go && (awaddr_q == pvod_pkg::BASE_VOLTAGE_SETTING_0_OFS);
  wire wr_base1 = wr_go && (awaddr_q == pvod_pkg::BASE_VOLTAGE_SETTING_1_OFS);
  wire wr_ctrl = wr_go && (awaddr_q == pvod_pkg::SCALING_CTRL_OFS);
  wire wr_cfg = wr_go && (awaddr_q == pvod_pkg::CONFIGURATION_WORD_0_OFS);

  assign s_axi_awready = !aw_held_q;
  assign s_axi_wready = !w_held_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign wr_hit = wr_base0 || wr_base1 || wr_ctrl || wr_cfg;
  assign ctrl_word = {26'h0, reg_on_q, 2'b00, enable_q};
  assign status_word = {16'h0, 2'b00, steps_q[1], 2'b00, steps_q[0]};
  assign rd_hit = (s_axi_araddr <= pvod_pkg::TARGET_1_OFS) && (s_axi_araddr[1:0] == 2'b00);
  always_comb begin
    unique case (s_axi_araddr)
      pvod_pkg::BASE_VOLTAGE_SETTING_0_OFS: rd_mux = {16'h0, base_q[0]};
      pvod_pkg::BASE_VOLTAGE_SETTING_1_OFS: rd_mux = {16'h0, base_q[1]};
      pvod_pkg::SCALING_CTRL_OFS: rd_mux = ctrl_word;
      pvod_pkg::CONFIGURATION_WORD_0_OFS: rd_mux = {31'h0, split_q};
      pvod_pkg::OFFSET_STATUS_OFS: rd_mux = status_word;
      pvod_pkg::TARGET_0_OFS: rd_mux = {16'h0, target_voltage_0};
      pvod_pkg::TARGET_1_OFS: rd_mux = {16'h0, target_voltage_1};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= pvod_pkg::RESP_OKAY;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= pvod_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_held_q) begin
        aw_held_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_held_q) begin
        w_held_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_hit ? pvod_pkg::RESP_OKAY : pvod_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
      if (s_axi_arvalid && !rvalid_q) begin
        rvalid_q <= 1'b1;
        rdata_q <= rd_mux;
        rresp_q <= rd_hit ? pvod_pkg::RESP_OKAY : pvod_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Control registers and offset state
  // ----------------------------------------
  // Only regulators 0 and 1 exist here; 2 and 3 have no scaling path at all
  wire [1:0] switched_off = reg_on_prev_q & ~reg_on_q;
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      base_q[0] <= pvod_pkg::BASE_VOLTAGE_RST;
      base_q[1] <= pvod_pkg::BASE_VOLTAGE_RST;
      enable_q <= 2'b00;
      reg_on_q <= 2'b00;
      reg_on_prev_q <= 2'b00;
      split_q <= 1'b0;
      steps_q[0] <= 6'h00;
      steps_q[1] <= 6'h00;
    end else begin
      reg_on_prev_q <= reg_on_q;
      if (wr_base0 && wstrb_q[0]) base_q[0][7:0] <= wdata_q[7:0]; // RQ5
      if (wr_base0 && wstrb_q[1]) base_q[0][15:8] <= wdata_q[15:8]; // RQ5
      if (wr_base1 && wstrb_q[0]) base_q[1][7:0] <= wdata_q[7:0]; // RQ5
      if (wr_base1 && wstrb_q[1]) base_q[1][15:8] <= wdata_q[15:8]; // RQ5
      if (wr_cfg && wstrb_q[0]) split_q <= wdata_q[pvod_pkg::PHASE_SPLIT_BIT]; // RQ11
      if (wr_ctrl && wstrb_q[0]) begin
        enable_q <= wdata_q[1:0]; // RQ2
        reg_on_q <= wdata_q[pvod_pkg::REG_ON_1_BIT:pvod_pkg::REG_ON_0_BIT];
      end
      // Switch-off clears the enable; it overrides a write in the same cycle
      if (switched_off[0]) enable_q[0] <= 1'b0; // RQ10
      if (switched_off[1]) enable_q[1] <= 1'b0; // RQ10
      for (int i = 0; i < 2; i++) begin
        if (!enable_q[i]) steps_q[i] <= 6'h00; // RQ1
        else if (frame_event[i]) steps_q[i] <= lk_count_q[i]; // RQ14
      end
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Half b never takes the link offset; only half a does when split
  logic [pvod_pkg::VOLT_W-1:0] tv0_q;
  logic [pvod_pkg::VOLT_W-1:0] tv1_q;
  logic [pvod_pkg::VOLT_W-1:0] tvb_q;
  logic a1_q;
  logic pg0_q;
  logic [2:0] pin_sync_q1;
  logic [2:0] pin_sync_q2;
  // Level inputs arrive from outside this clock; two flops before any use
  always_ff @(posedge ref_clk) begin
    pin_sync_q1 <= {external_regulator_enable_req, power_good_state_1, power_good_state_0};
    pin_sync_q2 <= pin_sync_q1;
  end
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      tv0_q <= 16'h0000;
      tv1_q <= 16'h0000;
      tvb_q <= 16'h0000;
      a1_q <= 1'b0;
      pg0_q <= 1'b0;
    end else begin
      tv0_q <= base_q[0] + 16'(steps_q[0]) * pvod_pkg::STEP_UV100; // RQ4 RQ13
      tv1_q <= base_q[1] + 16'(steps_q[1]) * pvod_pkg::STEP_UV100; // RQ4
      tvb_q <= split_q ? base_q[0] : 16'h0000; // RQ13
      a1_q <= split_q ? pin_sync_q2[1] : pin_sync_q2[2]; // RQ12
      pg0_q <= split_q ? 1'b0 : pin_sync_q2[0]; // RQ12
    end
  end
  assign target_voltage_0 = tv0_q;
  assign target_voltage_1 = tv1_q;
  assign target_voltage_split_b = tvb_q;
  assign phase_split_active = split_q;
  assign pin_a38_is_feedback = split_q; // RQ12
  assign pin_a1_out = a1_q;
  assign power_good_out_0 = pg0_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_off_clears;
    @(posedge ref_clk) disable iff (srst) $fell(reg_on_q[0]) |=> !enable_q[0];
  endproperty
  a_off_clears: assert property (p_off_clears) else $error("enable 0 kept after switch off"); // RQ10
  property p_disabled_zero;
    @(posedge ref_clk) disable iff (srst) !enable_q[1] |=> steps_q[1] == 6'h00;
  endproperty
  a_disabled_zero: assert property (p_disabled_zero) else $error("steps 1 nonzero while disabled"); // RQ1
  property p_steps_max;
    @(posedge ref_clk) disable iff (srst) steps_q[0] <= pvod_pkg::MAX_STEPS;
  endproperty
  a_steps_max: assert property (p_steps_max) else $error("steps exceed 32"); // RQ4
  property p_target;
    @(posedge ref_clk) disable iff (srst)
      1'b1 |=> tv1_q == $past(base_q[1]) + 16'($past(steps_q[1])) * pvod_pkg::STEP_UV100;
  endproperty
  a_target: assert property (p_target) else $error("target 1 not base plus offset"); // RQ4
  property p_split_pin;
    @(posedge ref_clk) disable iff (srst) split_q |=> !pg0_q;
  endproperty
  a_split_pin: assert property (p_split_pin) else $error("pg0 driven while split"); // RQ12
  property p_frame_applied;
    @(posedge ref_clk) disable iff (srst) (frame_event[0] && enable_q[0] && !switched_off[0]) |=> steps_q[0] == $past(lk_count_q[0]);
  endproperty
  a_frame_applied: assert property (p_frame_applied) else $error("frame count not applied"); // RQ14
  property p_half_b;
    @(posedge ref_clk) disable iff (srst) split_q |=> tvb_q == $past(base_q[0]);
  endproperty
  a_half_b: assert property (p_half_b) else $error("half b took offset"); // RQ13
  property p_split_write;
    @(posedge ref_clk) disable iff (srst) (wr_cfg && wstrb_q[0] && wdata_q[0]) |=> split_q;
  endproperty
  a_split_write: assert property (p_split_write) else $error("split bit not set"); // RQ11
  property p_disabled_zero_0;
    @(posedge ref_clk) disable iff (srst) !enable_q[0] |=> steps_q[0] == 6'h00;
  endproperty
  a_disabled_zero_0: assert property (p_disabled_zero_0) else $error("steps 0 nonzero while disabled"); // RQ1
  // Pin checks look one cycle back at the synchroniser output, not the raw pin
  property p_unsplit_pin;
    @(posedge ref_clk) disable iff (srst) !split_q |=> a1_q == $past(pin_sync_q2[2]);
  endproperty
  a_unsplit_pin: assert property (p_unsplit_pin) else $error("pin a1 not external enable when unsplit"); // RQ12
  property p_split_a1;
    @(posedge ref_clk) disable iff (srst) split_q |=> a1_q == $past(pin_sync_q2[1]);
  endproperty
  a_split_a1: assert property (p_split_a1) else $error("pin a1 not power good 1 when split"); // RQ12
  property p_unsplit_b;
    @(posedge ref_clk) disable iff (srst) !split_q |=> tvb_q == 16'h0000;
  endproperty
  a_unsplit_b: assert property (p_unsplit_b) else $error("half b target while unsplit"); // RQ13
  sequence s_frame_seen_1;
    frame_event[1] && enable_q[1];
  endsequence
  property p_frame_applied_1;
    @(posedge ref_clk) disable iff (srst) s_frame_seen_1 |=> steps_q[1] == $past(lk_count_q[1]);
  endproperty
  a_frame_applied_1: assert property (p_frame_applied_1) else $error("frame count 1 not applied"); // RQ14
  property p_base_write;
    @(posedge ref_clk) disable iff (srst)
      (wr_base1 && wstrb_q[0] && wstrb_q[1]) |=> base_q[1] == $past(wdata_q[15:0]);
  endproperty
  a_base_write: assert property (p_base_write) else $error("base 1 write lost"); // RQ5
endmodule // pvod_decoder

/* File: pvod_link_host.sv */
// Host model driving one voltage-offset link
`timescale 1ns/100ps
module pvod_link_host (
  output logic link_clk,
  output logic link_data
);
  initial begin
    link_clk = 1'b0;
    link_data = 1'b0;
  end
  // Data moves in the low phase only, so every rising edge sees settled data
  task automatic period(input logic d, input int hi, input int lo);
    link_data = d;
    #(lo);
    link_clk = 1'b1;
    #(hi);
    link_clk = 1'b0;
  endtask
  // Low lead-in gives the opening rising data edge; clock stands low after
  task automatic send(input logic [31:0] pat, input int hi, input int lo);
    repeat (4) period(1'b0, hi, lo);
    for (int i = 0; i < 32; i++) period(pat[i], hi, lo);
    link_data = 1'b0;
  endtask
endmodule // pvod_link_host

/* File: tb_top.sv */
// Self-checking bench for the voltage-offset link decoder
`timescale 1ns/100ps
module tb_top;
  logic ref_clk, srst, link_srst, link_clk_0, link_clk_1, general_io_2, general_io_5;
  logic power_good_state_0, power_good_state_1, external_regulator_enable_req;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [15:0] target_voltage_0, target_voltage_1, target_voltage_split_b;
  logic phase_split_active, pin_a38_is_feedback, pin_a1_out, power_good_out_0;
  int fail_count, comparisons;
  localparam logic [1:0] OK = pvod_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = pvod_pkg::RESP_SLVERR;
  localparam logic [7:0] CTRL = pvod_pkg::SCALING_CTRL_OFS;
  localparam logic [7:0] STAT = pvod_pkg::OFFSET_STATUS_OFS;
  localparam logic [15:0] B0 = 16'h1f40;
  localparam logic [15:0] B1 = 16'h2328;

  pvod_decoder uut (.ref_clk, .srst, .link_clk_0, .link_clk_1, .link_srst, .general_io_2, .general_io_5,
    .power_good_state_0, .power_good_state_1, .external_regulator_enable_req, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .target_voltage_0, .target_voltage_1, .target_voltage_split_b, .phase_split_active,
    .pin_a38_is_feedback, .pin_a1_out, .power_good_out_0);
  pvod_link_host host0 (.link_clk(link_clk_0), .link_data(general_io_5));
  pvod_link_host host1 (.link_clk(link_clk_1), .link_data(general_io_2));

  // ----------------------------------------
  // Checking and bus tasks
  // ----------------------------------------
  task automatic wrap_up();
    if (fail_count == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  function automatic logic [31:0] tgt(input logic [15:0] b, input logic [31:0] p);
    return {16'h0, b + 16'($countones(p)) * pvod_pkg::STEP_UV100};
  endfunction
  task automatic settle();
    repeat (12) @(posedge ref_clk);
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    @(posedge ref_clk);
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 40);
    s_axi_bready <= 1'b0;
    chk("bresp", {30'h0, s_axi_bresp}, {30'h0, r});
    if (n >= 40) begin
      chk("timeout", 32'h1, 32'h0);
      wrap_up();
    end
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    @(posedge ref_clk);
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 40);
    s_axi_rready <= 1'b0;
    chk("rdata", s_axi_rdata, d);
    chk("rresp", {30'h0, s_axi_rresp}, {30'h0, r});
    if (n >= 40) begin
      chk("timeout", 32'h1, 32'h0);
      wrap_up();
    end
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs();
    for (int i = 0; i < 7; i++) axi_rd(8'(i * 4), 32'h0, OK);
    axi_rd(8'h1c, 32'h0, ERR);
    axi_rd(8'h0d, 32'h0, ERR);
    axi_wr(8'h40, 32'h1, ERR);
    axi_rd(pvod_pkg::CONFIGURATION_WORD_0_OFS, 32'h0, OK);
    // Only byte lane 1 enabled: the low byte of the base must stay put
    s_axi_wstrb <= 4'h2;
    axi_wr(pvod_pkg::BASE_VOLTAGE_SETTING_1_OFS, 32'h0000_abcd, OK);
    s_axi_wstrb <= 4'hf;
    axi_rd(pvod_pkg::BASE_VOLTAGE_SETTING_1_OFS, 32'h0000_ab00, OK);
  endtask
  task automatic t_disabled();
    axi_wr(pvod_pkg::BASE_VOLTAGE_SETTING_0_OFS, {16'h0, B0}, OK);
    axi_wr(pvod_pkg::BASE_VOLTAGE_SETTING_1_OFS, {16'h0, B1}, OK);
    axi_wr(CTRL, 32'h30, OK);
    host0.send('1, 3, 3);
    settle();
    chk("target0", {16'h0, target_voltage_0}, {16'h0, B0});
    axi_rd(STAT, 32'h0, OK);
  endtask
  task automatic t_decode();
    axi_wr(CTRL, 32'h33, OK);
    fork
      host0.send('1, 3, 3);
      host1.send(32'h8000_0105, 3, 3);
    join
    settle();
    axi_rd(STAT, 32'h0420, OK);
    chk("target0", {16'h0, target_voltage_0}, tgt(B0, '1));
    chk("target1", {16'h0, target_voltage_1}, tgt(B1, 32'h8000_0105));
    axi_rd(pvod_pkg::TARGET_1_OFS, tgt(B1, 32'h8000_0105), OK);
  endtask
  task automatic t_rates();
    host0.send(32'h1, 17, 14);
    settle();
    chk("target0", {16'h0, target_voltage_0}, tgt(B0, 32'h1));
    host0.send(32'h0000_ffff, 100, 233);
    settle();
    chk("target0", {16'h0, target_voltage_0}, tgt(B0, 32'hffff));
  endtask
  task automatic t_turn_off();
    // Regulator 0 falls while enable 0 is rewritten as 1: the clear must win
    axi_wr(CTRL, 32'h23, OK);
    axi_rd(CTRL, 32'h22, OK);
    host0.send('1, 3, 3);
    settle();
    axi_rd(STAT, 32'h0400, OK);
    chk("target0", {16'h0, target_voltage_0}, {16'h0, B0});
  endtask
  task automatic t_split();
    settle();
    chk("pin_a1", {31'h0, pin_a1_out}, 32'h1);
    chk("pg0", {31'h0, power_good_out_0}, 32'h1);
    axi_wr(pvod_pkg::CONFIGURATION_WORD_0_OFS, 32'h1, OK);
    power_good_state_1 <= 1'b1;
    external_regulator_enable_req <= 1'b0;
    settle();
    chk("split", {29'h0, phase_split_active, pin_a38_is_feedback, power_good_out_0}, 32'h6);
    chk("pin_a1", {31'h0, pin_a1_out}, 32'h1);
    chk("half_b", {16'h0, target_voltage_split_b}, {16'h0, B0});
    axi_wr(CTRL, 32'h33, OK);
    host0.send(32'h3, 3, 3);
    settle();
    chk("target0", {16'h0, target_voltage_0}, tgt(B0, 32'h3));
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial begin
    {srst, link_srst} = 2'b11;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    {power_good_state_0, power_good_state_1, external_regulator_enable_req} = 3'b101;
    fail_count = 0;
    comparisons = 0;
    // Link resets need a few link edges while held
    fork
      repeat (4) host0.period(1'b0, 3, 3);
      repeat (4) host1.period(1'b0, 3, 3);
    join
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    link_srst <= 1'b0;
    t_regs();
    t_disabled();
    t_decode();
    t_rates();
    t_turn_off();
    t_split();
    wrap_up();
  end
endmodule // tb_top
